// file: ttr_timers.sv
// Three timers counting up, timer C prescaled and counting down in carrier mode, on Avalon-MM.
// Assumes a synchronous active-high reset and a master that holds its
// request until waitrequest is seen low.
//
// Functional notes
// - Carrier register bits 7..4 hold scale enable, code
// - Mask bits 5,4,3 enable C,B,A interrupts
// - Status bits 5,4,3 flag C,B,A; bit 2 zero
// - Timer B upper byte is own register
// - Count up, reload preset at wrap, set flag
// - Wide enable selects 16-bit, else 8-bit timer B
// - HF and infrared set: timer C makes carrier
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/100ps
module ttr_timers (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire ttr_pkg::ttr_avs_req_t avs_req,
	output logic                       avs_waitrequest,
	output logic                [31:0] avs_readdata,
	output logic                       irq,
	output logic                       carrier_wave
);
	import ttr_pkg::*;

	ttr_top_state_t q;
	ttr_top_state_t next_q;

	logic [5:0]  idx;
	logic        req;
	logic        accept;
	logic        wr_acc;
	logic [7:0]  wbyte;
	logic [7:0]  rbyte;
	logic        carrier_mode;
	logic [7:0]  presc_last;
	logic        tick_c;
	logic [15:0] a_count;
	logic [15:0] b_count;
	logic [15:0] c_count;
	logic [15:0] c_preset;
	logic        wrap_a;
	logic        wrap_b;
	logic        wrap_c;
	logic [7:0]  events;

	always_comb begin
		idx    = avs_req.address[7:2];
		req    = avs_req.read || avs_req.write;
		accept = req && !q.waitrequest;
		wr_acc = accept && avs_req.write;
		wbyte  = avs_req.writedata[7:0];
		carrier_mode = q.carrier_ctrl[BIT_HF] && q.carrier_ctrl[BIT_IRE];
		// Scale code n divides by 2^(n+1); off means every clock
		if (q.carrier_ctrl[BIT_C_SCALE_EN]) begin
			presc_last = 8'((9'h002 << q.carrier_ctrl[C_SCALE_LSB +: 3]) - 9'h001);
		end else begin
			presc_last = 8'h00;
		end
		tick_c = q.bc_ctrl[BIT_C_RUN] && (q.presc == presc_last);
	end

	ttr_timer_unit u_timer_a (
		.clk       (clk),
		.rst       (rst),
		.tick      (1'b1),
		.run       (q.a_ctrl[BIT_A_RUN]),
		.wide      (1'b0),
		.down      (1'b0),
		.load_lo   (wr_acc && (idx == IDX_A_COUNT)),
		.load_hi   (1'b0),
		.load_data (wbyte),
		.count     (a_count),
		.preset    (),
		.wrap      (wrap_a)
	);

	ttr_timer_unit u_timer_b (
		.clk       (clk),
		.rst       (rst),
		.tick      (1'b1),
		.run       (q.bc_ctrl[BIT_B_RUN]),
		.wide      (q.bc_ctrl[BIT_B_WIDE]),
		.down      (1'b0),
		.load_lo   (wr_acc && (idx == IDX_B_LOW)),
		.load_hi   (wr_acc && (idx == IDX_B_HIGH)),
		.load_data (wbyte),
		.count     (b_count),
		.preset    (),
		.wrap      (wrap_b)
	);

	// Carrier mode counts down so half period is (1 + preset) x scale
	ttr_timer_unit u_timer_c (
		.clk       (clk),
		.rst       (rst),
		.tick      (tick_c),
		.run       (q.bc_ctrl[BIT_C_RUN]),
		.wide      (1'b0),
		.down      (carrier_mode),
		.load_lo   (wr_acc && (idx == IDX_C_COUNT)),
		.load_hi   (1'b0),
		.load_data (wbyte),
		.count     (c_count),
		.preset    (c_preset),
		.wrap      (wrap_c)
	);

	always_comb begin
		events = RST_BYTE;
		events[BIT_IRQ_A] = wrap_a;
		events[BIT_IRQ_B] = wrap_b;
		// Carrier wraps are waveform edges, not timer events
		events[BIT_IRQ_C] = wrap_c && !carrier_mode;

		unique case (idx)
			IDX_A_COUNT: rbyte = a_count[7:0];
			IDX_B_LOW:   rbyte = b_count[7:0];
			IDX_B_HIGH:  rbyte = b_count[15:8];
			IDX_A_CTRL:  rbyte = q.a_ctrl;
			IDX_BC_CTRL: rbyte = q.bc_ctrl;
			IDX_CARRIER: rbyte = q.carrier_ctrl;
			IDX_STATUS:  rbyte = q.status;
			IDX_C_COUNT: rbyte = carrier_mode ? c_preset[7:0] : c_count[7:0];
			IDX_MASK:    rbyte = q.mask;
			default:     rbyte = RST_BYTE;
		endcase
	end

	always_comb begin
		next_q = q;
		// One wait state: data are captured, then the request is taken
		next_q.waitrequest = !(req && q.waitrequest);
		if (avs_req.read && q.waitrequest) begin
			next_q.readdata = {24'h00_0000, rbyte};
		end

		if (wr_acc) begin
			unique case (idx)
				IDX_A_CTRL:  next_q.a_ctrl       = wbyte & A_CTRL_MASK;
				IDX_BC_CTRL: next_q.bc_ctrl      = wbyte & BC_CTRL_MASK;
				IDX_CARRIER: next_q.carrier_ctrl = wbyte;
				IDX_MASK:    next_q.mask         = wbyte & IRQ_MASK;
				default:     next_q.mask         = q.mask;
			endcase
		end

		// Clear only what the reader saw; a new event still sets the flag
		if (accept && avs_req.read && (idx == IDX_STATUS)) begin
			next_q.status = q.status & ~q.readdata[7:0];
		end
		next_q.status = (next_q.status | events) & IRQ_MASK;

		if (!q.bc_ctrl[BIT_C_RUN] || tick_c) begin
			next_q.presc = RST_BYTE;
		end else begin
			next_q.presc = q.presc + 8'h01;
		end

		if (!carrier_mode) begin
			next_q.carrier = 1'b0;
		end else if (wrap_c) begin
			next_q.carrier = !q.carrier;
		end

		next_q.irq = |(next_q.status & q.mask);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '{a_ctrl: RST_BYTE, bc_ctrl: RST_BYTE, carrier_ctrl: RST_BYTE,
			       mask: RST_BYTE, status: RST_BYTE, presc: RST_BYTE,
			       carrier: 1'b0, irq: 1'b0, waitrequest: 1'b1,
			       readdata: RST_RDATA};
		end else begin
			q <= next_q;
		end
	end

	assign avs_waitrequest = q.waitrequest;
	assign avs_readdata    = q.readdata;
	assign irq             = q.irq;
	assign carrier_wave    = q.carrier;

endmodule : ttr_timers

// file: ttr_pkg.sv
// Constants, bus and state types for the three-timer register block.
// Assumes an Avalon-MM master with byte addresses and one 40 MHz clock.
package ttr_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_A_COUNT   = 6'h05;
	localparam logic [5:0] IDX_B_LOW     = 6'h06;
	localparam logic [5:0] IDX_B_HIGH    = 6'h07;
	localparam logic [5:0] IDX_A_CTRL    = 6'h08;
	localparam logic [5:0] IDX_BC_CTRL   = 6'h09;
	localparam logic [5:0] IDX_CARRIER   = 6'h0A;
	localparam logic [5:0] IDX_STATUS    = 6'h0F;
	localparam logic [5:0] IDX_C_COUNT   = 6'h18;
	localparam logic [5:0] IDX_MASK      = 6'h1F;

	// Field positions
	localparam int BIT_A_RUN      = 2;
	localparam int BIT_B_WIDE     = 7;
	localparam int BIT_B_RUN      = 6;
	localparam int BIT_C_RUN      = 2;
	localparam int BIT_C_SCALE_EN = 7;
	localparam int C_SCALE_LSB    = 4;
	localparam int BIT_IRE        = 3;
	localparam int BIT_HF         = 2;
	localparam int BIT_IRQ_C      = 5;
	localparam int BIT_IRQ_B      = 4;
	localparam int BIT_IRQ_A      = 3;

	// Values after reset
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;

	// Bit masks of implemented fields
	localparam logic [7:0] A_CTRL_MASK  = 8'h04;
	localparam logic [7:0] BC_CTRL_MASK = 8'hC4;
	localparam logic [7:0] IRQ_MASK     = 8'h38;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
	} ttr_avs_req_t;

	typedef struct packed {
		logic [15:0] count;
		logic [15:0] preset;
	} ttr_unit_state_t;

	typedef struct packed {
		logic [7:0]  a_ctrl;
		logic [7:0]  bc_ctrl;
		logic [7:0]  carrier_ctrl;
		logic [7:0]  mask;
		logic [7:0]  status;
		logic [7:0]  presc;
		logic        carrier;
		logic        irq;
		logic        waitrequest;
		logic [31:0] readdata;
	} ttr_top_state_t;

endpackage : ttr_pkg

// file: ttr_timer_unit.sv
// One reloading timer of up to 16 bits with byte-wise load.
// Assumes tick, run and loads come from the owning block's clock domain.
`timescale 1ns/100ps
module ttr_timer_unit (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        tick,
	input  wire logic        run,
	input  wire logic        wide,
	input  wire logic        down,
	input  wire logic        load_lo,
	input  wire logic        load_hi,
	input  wire logic [7:0]  load_data,
	output logic      [15:0] count,
	output logic      [15:0] preset,
	output logic             wrap
);
	import ttr_pkg::*;

	ttr_unit_state_t q;
	ttr_unit_state_t next_q;
	logic            terminal;

	always_comb begin
		next_q = q;
		// Narrow mode counts and wraps on the low byte; the upper byte holds
		if (down) begin
			terminal = wide ? (q.count == 16'h0000) : (q.count[7:0] == 8'h00);
		end else begin
			terminal = wide ? (q.count == 16'hFFFF) : (q.count[7:0] == 8'hFF);
		end
		wrap = tick && run && terminal;
		if (tick && run) begin
			if (terminal) begin
				next_q.count = wide ? q.preset : {q.count[15:8], q.preset[7:0]};
			end else if (wide) begin
				next_q.count = down ? q.count - 16'h0001 : q.count + 16'h0001;
			end else begin
				next_q.count[7:0] = down ? q.count[7:0] - 8'h01 : q.count[7:0] + 8'h01;
			end
		end
		// A write loads preset and live count together
		if (load_lo) begin
			next_q.count[7:0]  = load_data;
			next_q.preset[7:0] = load_data;
		end
		if (load_hi) begin
			next_q.count[15:8]  = load_data;
			next_q.preset[15:8] = load_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '{count: RST_WORD, preset: RST_WORD};
		end else begin
			q <= next_q;
		end
	end

	assign count  = q.count;
	assign preset = q.preset;

endmodule : ttr_timer_unit

// file: ttr_timers_assertions.sv
// Port checker for the three-timer block.
// Assumes byte addresses, register index in bits 7..2.
`timescale 1ns/100ps
module ttr_timers_assertions (
	input wire logic                  clk,
	input wire logic                  rst,
	input wire ttr_pkg::ttr_avs_req_t avs_req,
	input wire logic                  avs_waitrequest,
	input wire logic           [31:0] avs_readdata,
	input wire logic                  irq,
	input wire logic                  carrier_wave
);
	import ttr_pkg::*;
	logic       rd_ok;
	logic       wr_ok;
	logic [5:0] ix;
	logic [7:0] car_sh;
	logic [7:0] mask_sh;
	assign ix = avs_req.address[7:2];
	assign rd_ok = avs_req.read && !avs_waitrequest;
	assign wr_ok = avs_req.write && !avs_waitrequest;
	// Shadows follow accepted writes only
	always_ff @(posedge clk) begin
		if (rst) begin
			car_sh <= 8'h00;
			mask_sh <= 8'h00;
		end else if (wr_ok && ix == IDX_CARRIER) begin
			car_sh <= avs_req.writedata[7:0];
		end else if (wr_ok && ix == IDX_MASK) begin
			mask_sh <= avs_req.writedata[7:0];
		end
	end
	default clocking cb @(posedge clk); endclocking
	sequence s_req_new;
		$rose(avs_req.read || avs_req.write);
	endsequence
	a_wait_answer: assert property (disable iff (rst) s_req_new |=> !avs_waitrequest)
		else $error("request not answered next cycle");
	a_wait_pulse: assert property (disable iff (rst) $fell(avs_waitrequest) |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_carrier_read: assert property (disable iff (rst)
		rd_ok && ix == IDX_CARRIER |-> avs_readdata == {24'h0, car_sh})
		else $error("carrier register readback wrong");
	a_mask_read: assert property (disable iff (rst)
		rd_ok && ix == IDX_MASK |-> avs_readdata == {24'h0, mask_sh & IRQ_MASK})
		else $error("mask readback wrong");
	a_irq_masked: assert property (disable iff (rst)
		((mask_sh & IRQ_MASK) == 8'h00) [*2] |-> !irq)
		else $error("irq high with all masked");
	a_status_bits: assert property (disable iff (rst)
		rd_ok && ix == IDX_STATUS |-> (avs_readdata & ~{24'h0, IRQ_MASK}) == 0)
		else $error("status unused bits set");
	a_rst_irq: assert property (rst |=> !irq)
		else $error("irq high after reset");
	a_rst_wave: assert property (rst |=> !carrier_wave)
		else $error("carrier high after reset");
endmodule : ttr_timers_assertions

bind ttr_timers ttr_timers_assertions ttr_timers_assertions_i (.clk(clk), .rst(rst),
	.avs_req(avs_req), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
	.irq(irq), .carrier_wave(carrier_wave));

// file: testbench.sv
// Self-checking bench for the three-timer block.
// Assumes the checker is bound to the block.
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
	$display("Error %s exp %h got %h", n, e, g); end end
module testbench;
	import ttr_pkg::*;
	typedef struct {logic [5:0] ix; logic [7:0] d; logic [7:0] e;} ttr_row_t;
	logic         clk;
	logic         rst;
	ttr_avs_req_t req;
	logic         wr;
	logic         irq;
	logic         wave;
	logic  [31:0] rd;
	logic  [31:0] q;
	int           err_total = 0;
	int           num_checks = 0;
	int           cyc = 0;
	int           n;
	// Unimplemented bits must read zero
	ttr_row_t rows[10] = '{'{IDX_A_CTRL, 8'hFB, 8'h00}, '{IDX_BC_CTRL, 8'h3B, 8'h00},
		'{IDX_CARRIER, 8'hF3, 8'hF3}, '{IDX_MASK, 8'hFF, 8'h38}, '{IDX_A_COUNT, 8'h37, 8'h37},
		'{IDX_B_LOW, 8'hA5, 8'hA5}, '{IDX_B_HIGH, 8'h5A, 8'h5A}, '{IDX_C_COUNT, 8'hC3, 8'hC3},
		'{6'h01, 8'hFF, 8'h00}, '{IDX_STATUS, 8'hFF, 8'h00}};
	ttr_timers ttr_timers_i (.clk(clk), .rst(rst), .avs_req(req), .avs_waitrequest(wr),
		.avs_readdata(rd), .irq(irq), .carrier_wave(wave));
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			end_of_test();
		end
	end
	task end_of_test;
		$display("Checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test
	task bus(input logic w, input logic [5:0] ix, input logic [7:0] d);
		@(posedge clk);
		req <= '{read: !w, write: w, address: {ix, 2'b00}, writedata: {24'h0, d}};
		do @(posedge clk); while (wr !== 1'b0);
		q = rd;
		req <= '0;
	endtask : bus
	task rdc(input logic [5:0] ix, input logic [7:0] e);
		bus(1'b0, ix, 8'h00);
		`CHK("readdata", {24'h0, e}, q)
	endtask : rdc
	// Bounded wait; lo catches a period that is too short
	task wev(input logic s, input int lo, input int hi);
		n = 0;
		while ((s ? wave : irq) !== 1'b1 && n < hi) begin
			@(posedge clk);
			n++;
		end
		`CHK("event time", 1'b1, n >= lo && (s ? wave : irq) === 1'b1)
	endtask : wev
	initial begin
		rst = 1;
		req = '0;
		repeat (3) @(posedge clk);
		rst <= 0;
		foreach (rows[i]) rdc(rows[i].ix, 8'h00);
		foreach (rows[i]) begin
			bus(1'b1, rows[i].ix, rows[i].d);
			rdc(rows[i].ix, rows[i].e);
		end
		bus(1'b1, IDX_MASK, 8'h08);
		bus(1'b1, IDX_A_COUNT, 8'hF0);
		bus(1'b1, IDX_A_CTRL, 8'h04);
		wev(1'b0, 12, 20);
		bus(1'b1, IDX_A_CTRL, 8'h00);
		rdc(IDX_STATUS, 8'h08);
		// Irq drops at the clearing edge; look one edge later
		@(posedge clk);
		`CHK("irq", 1'b0, irq)
		rdc(IDX_STATUS, 8'h00);
		// Frozen count must read the same after idle cycles
		bus(1'b0, IDX_A_COUNT, 8'h00);
		repeat (8) @(posedge clk);
		rdc(IDX_A_COUNT, q[7:0]);
		bus(1'b1, IDX_MASK, 8'h10);
		bus(1'b1, IDX_B_HIGH, 8'h12);
		bus(1'b1, IDX_B_LOW, 8'hF0);
		bus(1'b1, IDX_BC_CTRL, 8'h40);
		wev(1'b0, 12, 20);
		bus(1'b1, IDX_BC_CTRL, 8'h00);
		rdc(IDX_B_HIGH, 8'h12);
		rdc(IDX_STATUS, 8'h10);
		bus(1'b1, IDX_B_HIGH, 8'hFE);
		bus(1'b1, IDX_B_LOW, 8'hF0);
		bus(1'b1, IDX_BC_CTRL, 8'hC0);
		wev(1'b0, 260, 290);
		bus(1'b1, IDX_BC_CTRL, 8'h00);
		rdc(IDX_STATUS, 8'h10);
		bus(1'b1, IDX_MASK, 8'h20);
		bus(1'b1, IDX_CARRIER, 8'h90);
		bus(1'b1, IDX_C_COUNT, 8'hF8);
		bus(1'b1, IDX_BC_CTRL, 8'h04);
		wev(1'b0, 28, 40);
		bus(1'b1, IDX_BC_CTRL, 8'h00);
		rdc(IDX_STATUS, 8'h20);
		bus(1'b1, IDX_CARRIER, 8'h0C);
		bus(1'b1, IDX_C_COUNT, 8'h02);
		bus(1'b1, IDX_BC_CTRL, 8'h04);
		wev(1'b1, 1, 20);
		rdc(IDX_C_COUNT, 8'h02);
		rdc(IDX_STATUS, 8'h00);
		// Reset in mid-run, with the carrier still toggling
		rst <= 1;
		repeat (3) @(posedge clk);
		rst <= 0;
		`CHK("wave", 1'b0, wave)
		`CHK("irq", 1'b0, irq)
		rdc(IDX_C_COUNT, 8'h00);
		rdc(IDX_CARRIER, 8'h00);
		rdc(IDX_BC_CTRL, 8'h00);
		end_of_test();
	end
endmodule : testbench
